/* File: verilog/pwmoc_top.sv */
// Module: PWM output pin control with APB register access
`timescale 1ns/1ps
// What this block does
// R1: High owner bit gives high pin to PWM
// R2: Low owner bit gives low pin to PWM
// R3: High invert bit makes high pin active low
// R4: Low invert bit makes low pin active low
// R5: Mode field selects complementary, independent, push-pull
// R6: High override enable drives high from override bit
// R7: Low override enable drives low from override bit
// R8: Active fault drives pins from fault values
// R9: Active current limit drives pins from limit values
// R10: Sync set: override changes at period boundary
// R11: Sync clear: override changes next clock
// R12: Divide 111 gives one trigger per eight
// R13: Postscaler starts counting after rollover match
// R14: Unimplemented bits ignore writes, read zero
// R15: Current limit substitution only when enabled
// R16: Divide value N passes every N+1 events
// R17: Priority fault, limit, override, generator; invert last
module pwmoc_top
  import pwmoc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] gen_pair,
  input wire logic period_boundary,
  input wire logic fault_active,
  input wire logic current_limit_active,
  input wire logic trigger_event,
  input wire logic [5:0] rollover_count,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic high_side_output,
  output logic high_side_oe,
  output logic low_side_output,
  output logic low_side_oe,
  output logic trigger_out
);

  // ---------------------------------------------------------------
  // Registers and APB slave
  // ---------------------------------------------------------------
  logic [15:0] pin_output_control;
  logic [15:0] trigger_control;
  logic current_limit_enable;
  logic access;
  logic wr;

  assign access = psel && penable;
  assign wr = access && pwrite;
  // Every access completes in its first access cycle, so no wait state
  assign pready = 1'b1;

  // Unmapped offsets answer with an error and leave every register alone
  always_comb begin
    if (paddr == PWMOC_TRIGGER_CONTROL_OFFSET || paddr == PWMOC_PIN_OUTPUT_CONTROL_OFFSET) begin
      pslverr = 1'b0;
    end else if (paddr == PWMOC_STATUS_OFFSET || paddr == PWMOC_CURRENT_LIMIT_OFFSET) begin
      pslverr = 1'b0;
    end else begin
      pslverr = access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_control <= PWMOC_PIN_OUTPUT_CONTROL_RESET;
    end else if (wr && paddr == PWMOC_PIN_OUTPUT_CONTROL_OFFSET) begin
      pin_output_control <= pwdata[15:0] & PWMOC_PIN_OUTPUT_CONTROL_MASK; // see R14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_control <= PWMOC_TRIGGER_CONTROL_RESET;
    end else if (wr && paddr == PWMOC_TRIGGER_CONTROL_OFFSET) begin
      trigger_control <= pwdata[15:0] & PWMOC_TRIGGER_CONTROL_MASK; // see R14
    end
  end

  // Limit substitution stays off after reset until software enables it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_limit_enable <= 1'b0;
    end else if (wr && paddr == PWMOC_CURRENT_LIMIT_OFFSET) begin
      current_limit_enable <= pwdata[PWMOC_CL_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic high_pin_owner;
  logic low_pin_owner;
  logic high_pin_invert;
  logic low_pin_invert;
  pwmoc_mode_t pin_pair_mode;
  logic high_override_enable;
  logic low_override_enable;
  pwmoc_pair_t override_value;
  pwmoc_pair_t fault_value;
  pwmoc_pair_t current_limit_value;
  logic override_sync_select;
  logic [2:0] trigger_divide;
  logic [5:0] trigger_start_count;

  assign high_pin_owner = pin_output_control[PWMOC_HIGH_OWNER_BIT];
  assign low_pin_owner = pin_output_control[PWMOC_LOW_OWNER_BIT];
  assign high_pin_invert = pin_output_control[PWMOC_HIGH_INVERT_BIT];
  assign low_pin_invert = pin_output_control[PWMOC_LOW_INVERT_BIT];
  assign pin_pair_mode = pwmoc_mode_t'(pin_output_control[PWMOC_MODE_LSB +: 2]);
  assign high_override_enable = pin_output_control[PWMOC_HIGH_OVR_EN_BIT];
  assign low_override_enable = pin_output_control[PWMOC_LOW_OVR_EN_BIT];
  assign override_value = pwmoc_pair_t'(pin_output_control[PWMOC_OVR_VALUE_LSB +: 2]);
  assign fault_value = pwmoc_pair_t'(pin_output_control[PWMOC_FAULT_VALUE_LSB +: 2]);
  assign current_limit_value = pwmoc_pair_t'(pin_output_control[PWMOC_CL_VALUE_LSB +: 2]);
  assign override_sync_select = pin_output_control[PWMOC_OVR_SYNC_BIT];
  assign trigger_divide = trigger_control[PWMOC_TRIG_DIV_LSB +: 3];
  assign trigger_start_count = trigger_control[PWMOC_TRIG_START_LSB +: 6];

  // ---------------------------------------------------------------
  // Pin-pair mode on the generator data
  // ---------------------------------------------------------------
  // Push-pull alternates the high-side waveform between pins each period.
  logic push_pull_phase;
  pwmoc_pair_t mode_pair;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_pull_phase <= 1'b0;
    end else if (period_boundary) begin
      push_pull_phase <= ~push_pull_phase;
    end
  end

  always_comb begin
    case (pin_pair_mode) // see R5
      PWMOC_MODE_COMPLEMENTARY: begin
        mode_pair.high = gen_pair[1];
        mode_pair.low = ~gen_pair[1];
      end
      PWMOC_MODE_INDEPENDENT: begin
        mode_pair.high = gen_pair[1];
        mode_pair.low = gen_pair[0];
      end
      PWMOC_MODE_PUSH_PULL: begin
        mode_pair.high = gen_pair[1] & ~push_pull_phase;
        mode_pair.low = gen_pair[1] & push_pull_phase;
      end
      default: begin
        // Reserved code: hold both pins inactive rather than guess
        mode_pair.high = 1'b0;
        mode_pair.low = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Override timing
  // ---------------------------------------------------------------
  logic ovr_high_en_eff;
  logic ovr_low_en_eff;
  pwmoc_pair_t ovr_value_eff;

  // Enables and data move together, so a pin never pairs a new enable with stale data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_high_en_eff <= 1'b0;
      ovr_low_en_eff <= 1'b0;
      ovr_value_eff <= '0;
    end else if (!override_sync_select || period_boundary) begin // see R10 // see R11
      ovr_high_en_eff <= high_override_enable;
      ovr_low_en_eff <= low_override_enable;
      ovr_value_eff <= override_value;
    end
  end

  // ---------------------------------------------------------------
  // Data selection and output stage
  // ---------------------------------------------------------------
  pwmoc_pair_t next_pin;

  always_comb begin
    // Later assignments win: fault over limit over override over generator
    next_pin = mode_pair;
    if (ovr_high_en_eff) begin
      next_pin.high = ovr_value_eff.high; // see R6
    end
    if (ovr_low_en_eff) begin
      next_pin.low = ovr_value_eff.low; // see R7
    end
    if (current_limit_active && current_limit_enable) begin // see R15 // see R17
      next_pin = current_limit_value; // see R9
    end
    if (fault_active) begin // see R17
      next_pin = fault_value; // see R8
    end
    // Inversion last, so substituted data are given in active-high terms
    next_pin.high = next_pin.high ^ high_pin_invert; // see R3
    next_pin.low = next_pin.low ^ low_pin_invert; // see R4
  end

  // Pins come from flip-flops so ownership hand-over is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_output <= 1'b0;
      high_side_oe <= 1'b0;
      low_side_output <= 1'b0;
      low_side_oe <= 1'b0;
    end else begin
      high_side_output <= high_pin_owner ? next_pin.high : gpio_out[1]; // see R1
      high_side_oe <= high_pin_owner ? 1'b1 : gpio_oe[1]; // see R1
      low_side_output <= low_pin_owner ? next_pin.low : gpio_out[0]; // see R2
      low_side_oe <= low_pin_owner ? 1'b1 : gpio_oe[0]; // see R2
    end
  end

  // ---------------------------------------------------------------
  // Trigger postscaler
  // ---------------------------------------------------------------
  pwmoc_trig_state_t trig_state;
  logic [2:0] trig_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_state <= PWMOC_TRIG_WAIT;
    end else if (wr && paddr == PWMOC_TRIGGER_CONTROL_OFFSET) begin
      // A new setting rearms the start match
      trig_state <= PWMOC_TRIG_WAIT;
    end else begin
      case (trig_state)
        PWMOC_TRIG_WAIT: begin
          if (rollover_count == trigger_start_count) begin // see R13
            trig_state <= PWMOC_TRIG_COUNT;
          end
        end
        default: begin
          trig_state <= PWMOC_TRIG_COUNT;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_count <= 3'h0;
      trigger_out <= 1'b0;
    end else if (trig_state == PWMOC_TRIG_COUNT && trigger_event) begin
      // Divide value N passes one output per N+1 counted events
      if (trig_count >= trigger_divide) begin // see R12 // see R16
        trig_count <= 3'h0;
        trigger_out <= 1'b1;
      end else begin
        trig_count <= trig_count + 3'h1;
        trigger_out <= 1'b0;
      end
    end else begin
      if (trig_state == PWMOC_TRIG_WAIT) begin
        trig_count <= 3'h0;
      end
      trigger_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  // Read-only snapshot of the postscaler and pin state for software
  logic [7:0] status_word;

  assign status_word = {1'b0, trig_count, trig_state, push_pull_phase, high_side_output, low_side_output};

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Read data is loaded in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == PWMOC_TRIGGER_CONTROL_OFFSET) begin
        prdata <= {16'h0000, trigger_control};
      end else if (paddr == PWMOC_PIN_OUTPUT_CONTROL_OFFSET) begin
        prdata <= {16'h0000, pin_output_control};
      end else if (paddr == PWMOC_STATUS_OFFSET) begin
        prdata <= {24'h000000, status_word};
      end else if (paddr == PWMOC_CURRENT_LIMIT_OFFSET) begin
        prdata <= {31'h0000_0000, current_limit_enable};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : pwmoc_top

/* File: common/pwmoc_pkg.sv */
// Package: register map, field positions and types for the PWM output pin control block
package pwmoc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PWMOC_TRIGGER_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] PWMOC_PIN_OUTPUT_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] PWMOC_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] PWMOC_CURRENT_LIMIT_OFFSET = 8'h0c;

  localparam logic [15:0] PWMOC_PIN_OUTPUT_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PWMOC_TRIGGER_CONTROL_RESET = 16'h0000;
  // Writable bits; bit 1 of pin control and bits 12-6 of trigger control read zero
  localparam logic [15:0] PWMOC_PIN_OUTPUT_CONTROL_MASK = 16'hfffd;
  localparam logic [15:0] PWMOC_TRIGGER_CONTROL_MASK = 16'he03f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PWMOC_HIGH_OWNER_BIT = 15;
  localparam int PWMOC_LOW_OWNER_BIT = 14;
  localparam int PWMOC_HIGH_INVERT_BIT = 13;
  localparam int PWMOC_LOW_INVERT_BIT = 12;
  localparam int PWMOC_MODE_LSB = 10;
  localparam int PWMOC_HIGH_OVR_EN_BIT = 9;
  localparam int PWMOC_LOW_OVR_EN_BIT = 8;
  localparam int PWMOC_OVR_VALUE_LSB = 6;
  localparam int PWMOC_FAULT_VALUE_LSB = 4;
  localparam int PWMOC_CL_VALUE_LSB = 2;
  localparam int PWMOC_OVR_SYNC_BIT = 0;
  localparam int PWMOC_TRIG_DIV_LSB = 13;
  localparam int PWMOC_TRIG_START_LSB = 0;
  localparam int PWMOC_CL_ENABLE_BIT = 0;

  typedef enum logic [1:0] {
    PWMOC_MODE_COMPLEMENTARY = 2'b00,
    PWMOC_MODE_INDEPENDENT = 2'b01,
    PWMOC_MODE_PUSH_PULL = 2'b10,
    PWMOC_MODE_RESERVED = 2'b11
  } pwmoc_mode_t;

  // Trigger postscaler states, gray along waiting -> counting
  typedef enum logic [0:0] {
    PWMOC_TRIG_WAIT = 1'b0,
    PWMOC_TRIG_COUNT = 1'b1
  } pwmoc_trig_state_t;

  // One pin pair travels together
  typedef struct packed {
    logic high;
    logic low;
  } pwmoc_pair_t;

endpackage : pwmoc_pkg

/* File: dv/pwmoc_monitor.sv */
// Checker for pin data selection and override timing
`timescale 1ns/1ps
module pwmoc_monitor
  import pwmoc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [1:0] gen_pair,
  input wire logic period_boundary,
  input wire logic fault_active,
  input wire logic current_limit_active,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  input wire logic high_side_output,
  input wire logic high_side_oe,
  input wire logic low_side_output,
  input wire logic low_side_oe
);
  logic [15:0] ctl;
  logic cl_en;
  logic [3:0] ovr;
  wire wr = psel & penable & pwrite & pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 16'h0000;
      cl_en <= 1'b0;
    end else if (wr && paddr == PWMOC_PIN_OUTPUT_CONTROL_OFFSET) begin
      ctl <= pwdata[15:0] & PWMOC_PIN_OUTPUT_CONTROL_MASK;
    end else if (wr && paddr == PWMOC_CURRENT_LIMIT_OFFSET) begin
      cl_en <= pwdata[0];
    end
  end
  // Override in force lags the register one edge, or waits for the period end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr <= 4'h0;
    end else if (!ctl[0] || period_boundary) begin
      ovr <= ctl[9:6];
    end
  end
  wire cl_on = current_limit_active & cl_en & !fault_active;
  wire free = !fault_active & !cl_on;
  wire [1:0] e_flt = ctl[5:4] ^ ctl[13:12];
  wire [1:0] e_cl = ctl[3:2] ^ ctl[13:12];
  wire [1:0] e_ovr = ovr[1:0] ^ ctl[13:12];
  wire e_gen = gen_pair[1] ^ ctl[13];
  wire e_comp = ~gen_pair[1] ^ ctl[12];
  wire e_ind = gen_pair[0] ^ ctl[12];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_high_gpio;
    !ctl[15] |=> high_side_output == $past(gpio_out[1]) && high_side_oe == $past(gpio_oe[1]);
  endproperty
  a_high_gpio: assert property (p_high_gpio) else $error("high pin ignores gpio");
  property p_low_gpio;
    !ctl[14] |=> low_side_output == $past(gpio_out[0]) && low_side_oe == $past(gpio_oe[0]);
  endproperty
  a_low_gpio: assert property (p_low_gpio) else $error("low pin ignores gpio");
  property p_fault_high;
    fault_active && ctl[15] |=> high_side_oe && high_side_output == $past(e_flt[1]);
  endproperty
  a_fault_high: assert property (p_fault_high) else $error("high fault data");
  property p_fault_low;
    fault_active && ctl[14] |=> low_side_oe && low_side_output == $past(e_flt[0]);
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("low fault data");
  property p_limit_low;
    cl_on && ctl[14] |=> low_side_output == $past(e_cl[0]);
  endproperty
  a_limit_low: assert property (p_limit_low) else $error("low limit data");
  property p_limit_off;
    free && current_limit_active && ctl[15] && !ovr[3] && ctl[11:10] == 2'b00 |=> high_side_output == $past(e_gen);
  endproperty
  a_limit_off: assert property (p_limit_off) else $error("limit data while disabled");
  property p_ovr_high;
    free && ctl[15] && ovr[3] |=> high_side_output == $past(e_ovr[1]);
  endproperty
  a_ovr_high: assert property (p_ovr_high) else $error("high override data");
  property p_comp_low;
    free && ctl[14] && !ovr[2] && ctl[11:10] == 2'b00 |=> low_side_output == $past(e_comp);
  endproperty
  a_comp_low: assert property (p_comp_low) else $error("complementary low");
  property p_ind_low;
    free && ctl[14] && !ovr[2] && ctl[11:10] == 2'b01 |=> low_side_output == $past(e_ind);
  endproperty
  a_ind_low: assert property (p_ind_low) else $error("independent low");
endmodule : pwmoc_monitor

bind pwmoc_top pwmoc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .gen_pair, .period_boundary, .fault_active, .current_limit_active, .gpio_out, .gpio_oe,
  .high_side_output, .high_side_oe, .low_side_output, .low_side_oe);

/* File: dv/pwmoc_stage.sv */
// Model of the power stage gate inputs fed by the two pins
`timescale 1ns/1ps
module pwmoc_stage (
  input wire logic high_side_output,
  input wire logic high_side_oe,
  input wire logic low_side_output,
  input wire logic low_side_oe,
  output logic gate_high,
  output logic gate_low
);
  // Gate inputs carry pull-downs, so a released pin reads as switch off
  assign gate_high = high_side_oe ? high_side_output : 1'b0;
  assign gate_low = low_side_oe ? low_side_output : 1'b0;
endmodule : pwmoc_stage

/* File: dv/test_pwm_output_pin_control.sv */
// Self-checking bench for the PWM output pin control block
`timescale 1ns/1ps
module test_pwm_output_pin_control
  import pwmoc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] gen_pair = 2'b00, gpio_out = 2'b11, gpio_oe = 2'b01;
  logic period_boundary = 1'b0, fault_active = 1'b0, current_limit_active = 1'b0, trigger_event = 1'b0;
  logic [5:0] rollover_count = 6'h00;
  logic pready, pslverr, err, high_side_output, high_side_oe, low_side_output, low_side_oe;
  logic trigger_out, gate_high, gate_low;
  logic [15:0] mctl [4] = '{16'hc000, 16'hc400, 16'hf400, 16'hc800};
  logic [1:0] mexp [4] = '{2'b10, 2'b11, 2'b00, 2'b10};
  int errors = 0, checks = 0, cycles = 0, outs = 0;
  always #12.5 pclk = ~pclk;
  pwmoc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gen_pair, .period_boundary, .fault_active, .current_limit_active, .trigger_event, .rollover_count,
    .gpio_out, .gpio_oe, .high_side_output, .high_side_oe, .low_side_output, .low_side_oe, .trigger_out);
  pwmoc_stage stage (.high_side_output, .high_side_oe, .low_side_output, .low_side_oe, .gate_high, .gate_low);
  task automatic print_verdict;
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pin_chk(input int n, input logic [1:0] e);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    chk({30'h0, gate_high, gate_low}, {30'h0, e});
  endtask : pin_chk
  task automatic events(input int n);
    repeat (n) begin
      @(posedge pclk);
      trigger_event <= 1'b1;
      @(posedge pclk);
      trigger_event <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : events
  task automatic arm;
    @(posedge pclk);
    rollover_count <= 6'h05;
    @(posedge pclk);
    rollover_count <= 6'h00;
  endtask : arm
  always @(posedge pclk) begin
    if (trigger_out === 1'b1) outs <= outs + 1;
    cycles++;
    if (cycles == 4000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    pin_chk(2, 2'b01);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'hffffffff);
    pin_chk(2, 2'b11);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000fffd);
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000e03f);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    gen_pair <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, {16'h0, mctl[i]});
      pin_chk(2, mexp[i]);
    end
    @(posedge pclk);
    period_boundary <= 1'b1;
    @(posedge pclk);
    period_boundary <= 1'b0;
    pin_chk(2, 2'b01);
    apb(1'b1, 8'h04, 32'h0000c340);
    pin_chk(1, 2'b10);
    pin_chk(1, 2'b01);
    apb(1'b1, 8'h04, 32'h0000c381);
    pin_chk(3, 2'b01);
    @(posedge pclk);
    period_boundary <= 1'b1;
    @(posedge pclk);
    period_boundary <= 1'b0;
    pin_chk(1, 2'b10);
    apb(1'b1, 8'h04, 32'h0000c00c);
    current_limit_active <= 1'b1;
    pin_chk(3, 2'b10);
    apb(1'b1, 8'h0c, 32'h1);
    pin_chk(2, 2'b11);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h1);
    @(posedge pclk);
    fault_active <= 1'b1;
    pin_chk(2, 2'b00);
    apb(1'b1, 8'h00, 32'h0000e005);
    events(8);
    chk(outs, 32'h0);
    arm();
    events(7);
    chk(outs, 32'h0);
    events(1);
    chk(outs, 32'h1);
    apb(1'b1, 8'h00, 32'h00000005);
    arm();
    events(3);
    chk(outs, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h8);
    print_verdict();
  end
endmodule : test_pwm_output_pin_control
